// File: hli_pkg.sv
// Constants and types shared by the data link interrupt status and enable block.
package hli_pkg;

    // Register index of the enable register within a channel page; the channel nibble sits above it.
    localparam logic [11:0] ENABLE_INDEX_LOW = 12'hB07;
    // Register index of the status register within a channel page.
    localparam logic [11:0] STATUS_INDEX_LOW = 12'hB06;
    // Width of the register index: one channel nibble over twelve bits.
    localparam int          INDEX_WIDTH      = 16;
    // Byte address width: the byte address is four times the register index.
    localparam int          ADDR_WIDTH       = 18;
    localparam int          DATA_WIDTH       = 32;
    localparam int          REG_WIDTH        = 8;

    // Bit positions of the status register; bits 0 to 6 are shared with the enable register.
    localparam int BIT_IDLE         = 0;
    localparam int BIT_ABORT        = 1;
    localparam int BIT_FRAME_CHECK  = 2;
    localparam int BIT_RX_END       = 3;
    localparam int BIT_TX_END       = 4;
    localparam int BIT_RX_START     = 5;
    localparam int BIT_TX_START     = 6;
    localparam int BIT_MESSAGE_KIND = 7;

    // Values after reset.
    localparam logic [6:0] FLAGS_RESET  = 7'h00;
    localparam logic [6:0] ENABLE_RESET = 7'h00;
    localparam logic [7:0] SHIFT_RESET  = 8'h00;
    localparam logic [2:0] ONES_RESET   = 3'h0;

    // Receive line patterns.
    localparam logic [7:0] IDLE_OCTET   = 8'h7E;
    localparam logic [2:0] ABORT_ONES   = 3'h7;

    // Message kind encoding in status bit 7.
    localparam logic BIT_ORIENTED_SIGNALING     = 1'b0;
    localparam logic MESSAGE_ORIENTED_SIGNALING = 1'b1;

    // Bus answer states.
    typedef enum logic [1:0] {
        HLI_BUS_IDLE = 2'b00,
        HLI_BUS_ANSWER = 2'b01
    } hli_bus_state_t;

    // Event pulses from the transmit and receive framing engines, one cycle each.
    typedef struct packed {
        logic transmit_start_flag;
        logic receive_start_flag;
        logic transmit_end_flag;
        logic receive_end_flag;
        logic frame_check_fail_flag;
    } hli_engine_events_t;

endpackage

// File: hli_irq_status.sv
// Data link status flags, interrupt enables and Avalon-MM register slave for one channel.
`timescale 1ns/1ns

// Function
// R1: Frame check failure sets status bit 2.
// R2: Seven consecutive ones set abort bit 1.
// R3: Received octet 0x7E sets idle bit 0.
// R4: Software reads idle plus end as complete.
// R5: Flags sticky, cleared by read, reset zero.
// R6: Enable bit 6 gates transmit start interrupt.
// R7: Enable bit 5 gates receive start interrupt.
// R8: Enable bit 4 gates transmit end interrupt.
// R9: Enable bit 3 gates receive end interrupt.
// R10: Enable bit 2 gates frame check interrupt.
// R11: Enable bit 1 gates abort interrupt.
// R12: Enable bit 0 gates idle interrupt.
// R13: Seven enables read/write, reset zero, bit 7 reserved.
// R14: Message end or buffer full sets bit 3.
// R15: Transmit start sets bit 6, end bit 4.
// R16: Status bit 7 shows message kind, read-only.
// R17: Interrupt high while enabled flag set.
module hli_irq_status #(
    parameter logic [3:0] CHANNEL = 4'h0
) (
    input  wire logic                             clk_sys,
    input  wire logic                             rst,
    input  wire logic [hli_pkg::ADDR_WIDTH-1:0]   avs_address,
    input  wire logic                             avs_read,
    input  wire logic                             avs_write,
    input  wire logic [hli_pkg::DATA_WIDTH-1:0]   avs_writedata,
    input  wire logic [3:0]                       avs_byteenable,
    output logic      [hli_pkg::DATA_WIDTH-1:0]   avs_readdata,
    output logic                                  avs_waitrequest,
    input  wire hli_pkg::hli_engine_events_t      engine_events,
    input  wire logic                             receive_buffer_full,
    input  wire logic                             message_kind_bit,
    input  wire logic                             rx_line_bit,
    input  wire logic                             rx_line_valid,
    output logic                                  irq
);

    localparam logic [hli_pkg::INDEX_WIDTH-1:0] ENABLE_INDEX = {CHANNEL, hli_pkg::ENABLE_INDEX_LOW};
    localparam logic [hli_pkg::INDEX_WIDTH-1:0] STATUS_INDEX = {CHANNEL, hli_pkg::STATUS_INDEX_LOW};

    // Register index of a byte address; the two low bits select a byte lane and are ignored.
    function automatic logic [hli_pkg::INDEX_WIDTH-1:0] index_of(input logic [hli_pkg::ADDR_WIDTH-1:0] addr);
        index_of = addr[hli_pkg::ADDR_WIDTH-1:2];
    endfunction

    // Receive line monitor: octet shift register and run of ones.
    logic [7:0] shift;
    logic [7:0] next_shift;
    logic [2:0] ones;
    logic [2:0] next_ones;
    logic       idle_seen;
    logic       abort_seen;

    always_comb begin
        next_shift = shift;
        next_ones  = ones;
        idle_seen  = 1'b0;
        abort_seen = 1'b0;
        if (rx_line_valid) begin
            next_shift = {shift[6:0], rx_line_bit};
            // A run longer than seven keeps reporting abort every further one bit.
            if (!rx_line_bit) begin
                next_ones = hli_pkg::ONES_RESET;
            end else if (ones != hli_pkg::ABORT_ONES) begin
                next_ones = ones + 3'h1;
            end
            idle_seen  = (next_shift == hli_pkg::IDLE_OCTET);  // [R3]
            abort_seen = rx_line_bit && (ones >= 3'h6);         // [R2]
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            shift <= hli_pkg::SHIFT_RESET;
            ones  <= hli_pkg::ONES_RESET;
        end else begin
            shift <= next_shift;
            ones  <= next_ones;
        end
    end

    // Gather all events into the status bit layout.
    logic [6:0] events;

    always_comb begin
        events                             = 7'h00;
        events[hli_pkg::BIT_IDLE]          = idle_seen;                                  // [R3]
        events[hli_pkg::BIT_ABORT]         = abort_seen;                                 // [R2]
        events[hli_pkg::BIT_FRAME_CHECK]   = engine_events.frame_check_fail_flag;       // [R1]
        events[hli_pkg::BIT_RX_END]        = engine_events.receive_end_flag || receive_buffer_full;  // [R14]
        events[hli_pkg::BIT_TX_END]        = engine_events.transmit_end_flag;           // [R15]
        events[hli_pkg::BIT_RX_START]      = engine_events.receive_start_flag;          // [R7]
        events[hli_pkg::BIT_TX_START]      = engine_events.transmit_start_flag;         // [R15]
    end

    // Bus slave: every access answers in the cycle after it is seen, with one wait cycle.
    hli_pkg::hli_bus_state_t bus_state;
    hli_pkg::hli_bus_state_t next_bus_state;
    logic [hli_pkg::DATA_WIDTH-1:0] readdata;
    logic [hli_pkg::DATA_WIDTH-1:0] next_readdata;
    logic                           hit_status;
    logic                           hit_enable;
    logic                           answering;

    assign hit_status = (index_of(avs_address) == STATUS_INDEX);
    assign hit_enable = (index_of(avs_address) == ENABLE_INDEX);
    assign answering  = (bus_state == hli_pkg::HLI_BUS_ANSWER);

    // Flags and enables.
    logic [6:0] flags;
    logic [6:0] next_flags;
    logic [6:0] enable;
    logic [6:0] next_enable;
    logic [6:0] clear_mask;
    logic       irq_reg;
    logic       next_irq;

    always_comb begin
        next_bus_state = bus_state;
        next_readdata  = readdata;
        case (bus_state)
            hli_pkg::HLI_BUS_IDLE: begin
                if (avs_read || avs_write) begin
                    next_bus_state = hli_pkg::HLI_BUS_ANSWER;
                    next_readdata  = '0;
                    if (avs_read && hit_status) begin
                        next_readdata[7:0] = {message_kind_bit, flags};  // [R16]
                    end else if (avs_read && hit_enable) begin
                        // Reserved bit 7 reads as zero.
                        next_readdata[7:0] = {1'b0, enable};  // [R13]
                    end
                end
            end
            hli_pkg::HLI_BUS_ANSWER: begin
                next_bus_state = hli_pkg::HLI_BUS_IDLE;
            end
            default: begin
                next_bus_state = hli_pkg::HLI_BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            bus_state <= hli_pkg::HLI_BUS_IDLE;
            readdata  <= '0;
        end else begin
            bus_state <= next_bus_state;
            readdata  <= next_readdata;
        end
    end

    assign avs_waitrequest = (avs_read || avs_write) && !answering;
    assign avs_readdata    = readdata;

    always_comb begin
        clear_mask  = 7'h00;
        next_enable = enable;
        if (answering && avs_read && hit_status) begin
            // Only flags that the read actually returned are cleared, so an event after the snapshot survives.
            clear_mask = readdata[6:0];  // [R5]
        end
        if (answering && avs_write && hit_status && avs_byteenable[0]) begin
            clear_mask = avs_writedata[6:0];
        end
        if (answering && avs_write && hit_enable && avs_byteenable[0]) begin
            next_enable = avs_writedata[6:0];  // [R13]
        end
        // A new event wins over a clear in the same cycle.
        next_flags = (flags & ~clear_mask) | events;  // [R5]
        next_irq   = |(next_flags & next_enable);    // [R6] [R7] [R8] [R9] [R10] [R11] [R12] [R17]
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            flags   <= hli_pkg::FLAGS_RESET;   // [R5]
            enable  <= hli_pkg::ENABLE_RESET;  // [R13]
            irq_reg <= 1'b0;
        end else begin
            flags   <= next_flags;
            enable  <= next_enable;
            irq_reg <= next_irq;
        end
    end

    assign irq = irq_reg;

    // Checks.
    a_frame_check_sets: assert property (@(posedge clk_sys) disable iff (rst)  // [R1]
        engine_events.frame_check_fail_flag |=> flags[hli_pkg::BIT_FRAME_CHECK])
        else $error("Frame check failure did not set its flag.");

    a_abort_run_sets: assert property (@(posedge clk_sys) disable iff (rst)  // [R2]
        (rx_line_valid && rx_line_bit && ones >= 3'h6) |=> flags[hli_pkg::BIT_ABORT])
        else $error("Seven ones did not set the abort flag.");

    a_abort_short_quiet: assert property (@(posedge clk_sys) disable iff (rst)  // [R2]
        (ones < 3'h6 || !rx_line_bit || !rx_line_valid) |-> !abort_seen)
        else $error("Abort reported before seven ones.");

    a_ones_saturate: assert property (@(posedge clk_sys) disable iff (rst)  // [R2]
        (rx_line_valid && rx_line_bit && ones == 3'h7) |=> (ones == 3'h7))
        else $error("Run of ones counter wrapped.");

    a_zero_ends_run: assert property (@(posedge clk_sys) disable iff (rst)  // [R2]
        (rx_line_valid && !rx_line_bit) |=> (ones == 3'h0))
        else $error("A zero bit did not end the run of ones.");

    a_idle_octet_sets: assert property (@(posedge clk_sys) disable iff (rst)  // [R3]
        (rx_line_valid && {shift[6:0], rx_line_bit} == hli_pkg::IDLE_OCTET) |=> flags[hli_pkg::BIT_IDLE])
        else $error("Idle octet did not set the idle flag.");

    a_line_quiet_holds: assert property (@(posedge clk_sys) disable iff (rst)  // [R3]
        !rx_line_valid |=> (shift == $past(shift) && ones == $past(ones)))
        else $error("Line monitor moved without a valid bit.");

    a_read_clears_flags: assert property (@(posedge clk_sys) disable iff (rst)  // [R5]
        (answering && avs_read && hit_status && events == 7'h00) |=> ((flags & $past(readdata[6:0])) == 7'h00))
        else $error("Status read did not clear the flags it returned.");

    a_flags_hold_set: assert property (@(posedge clk_sys) disable iff (rst)  // [R5]
        (flags != 7'h00 && !(answering && hit_status)) |=> ((flags & $past(flags)) == $past(flags)))
        else $error("A status flag dropped without a clear.");

    a_no_spurious_set: assert property (@(posedge clk_sys) disable iff (rst)  // [R5]
        ##1 ((flags & ~$past(flags) & ~$past(events)) == 7'h00))
        else $error("A status flag rose without its event.");

    a_event_beats_clear: assert property (@(posedge clk_sys) disable iff (rst)  // [R5]
        ##1 ((flags & $past(events)) == $past(events)))
        else $error("An event was lost against a clear.");

    a_write_one_clears: assert property (@(posedge clk_sys) disable iff (rst)  // [R5]
        (answering && avs_write && hit_status && avs_byteenable[0] && events == 7'h00)
        |=> ((flags & $past(avs_writedata[6:0])) == 7'h00))
        else $error("Writing ones did not clear the flags.");

    a_status_reads_back: assert property (@(posedge clk_sys) disable iff (rst)  // [R5]
        (!answering && avs_read && hit_status) |=> (avs_readdata[6:0] == $past(flags)))
        else $error("Status read did not return the flags.");

    a_tx_start_gate: assert property (@(posedge clk_sys) disable iff (rst)  // [R6]
        (flags[hli_pkg::BIT_TX_START] && enable[hli_pkg::BIT_TX_START]) |-> irq)
        else $error("Enabled transmit start did not interrupt.");

    a_disabled_irq_low: assert property (@(posedge clk_sys) disable iff (rst)  // [R6]
        (enable == 7'h00 && next_enable == 7'h00) |=> !irq)
        else $error("Interrupt raised with all enables clear.");

    a_rx_start_gate: assert property (@(posedge clk_sys) disable iff (rst)  // [R7]
        (flags[hli_pkg::BIT_RX_START] && enable[hli_pkg::BIT_RX_START]) |-> irq)
        else $error("Enabled receive start did not interrupt.");

    a_rx_start_sets: assert property (@(posedge clk_sys) disable iff (rst)  // [R7]
        engine_events.receive_start_flag |=> flags[hli_pkg::BIT_RX_START])
        else $error("Receive start did not set its flag.");

    a_tx_end_gate: assert property (@(posedge clk_sys) disable iff (rst)  // [R8]
        (flags[hli_pkg::BIT_TX_END] && enable[hli_pkg::BIT_TX_END]) |-> irq)
        else $error("Enabled transmit end did not interrupt.");

    a_rx_end_gate: assert property (@(posedge clk_sys) disable iff (rst)  // [R9]
        (flags[hli_pkg::BIT_RX_END] && enable[hli_pkg::BIT_RX_END]) |-> irq)
        else $error("Enabled receive end did not interrupt.");

    a_frame_check_gate: assert property (@(posedge clk_sys) disable iff (rst)  // [R10]
        (flags[hli_pkg::BIT_FRAME_CHECK] && enable[hli_pkg::BIT_FRAME_CHECK]) |-> irq)
        else $error("Enabled frame check failure did not interrupt.");

    a_abort_gate: assert property (@(posedge clk_sys) disable iff (rst)  // [R11]
        (flags[hli_pkg::BIT_ABORT] && enable[hli_pkg::BIT_ABORT]) |-> irq)
        else $error("Enabled abort did not interrupt.");

    a_idle_gate: assert property (@(posedge clk_sys) disable iff (rst)  // [R12]
        (flags[hli_pkg::BIT_IDLE] && enable[hli_pkg::BIT_IDLE]) |-> irq)
        else $error("Enabled idle octet did not interrupt.");

    a_enable_write_takes: assert property (@(posedge clk_sys) disable iff (rst)  // [R13]
        (answering && avs_write && hit_enable && avs_byteenable[0]) |=> (enable == $past(avs_writedata[6:0])))
        else $error("Enable write was not stored.");

    a_enable_holds: assert property (@(posedge clk_sys) disable iff (rst)  // [R13]
        !(answering && avs_write && hit_enable && avs_byteenable[0]) |=> (enable == $past(enable)))
        else $error("Enable changed without a write.");

    a_enable_reads_back: assert property (@(posedge clk_sys) disable iff (rst)  // [R13]
        (!answering && avs_read && hit_enable) |=> (avs_readdata[6:0] == $past(enable)))
        else $error("Enable read did not return the enables.");

    a_reserved_reads_zero: assert property (@(posedge clk_sys) disable iff (rst)  // [R13]
        (!answering && avs_read && hit_enable) |=> !avs_readdata[7])
        else $error("Reserved enable bit read as one.");

    a_unmapped_read_zero: assert property (@(posedge clk_sys) disable iff (rst)  // [R13]
        (!answering && avs_read && !hit_status && !hit_enable) |=> (avs_readdata == 32'h0))
        else $error("Unmapped read returned data.");

    a_upper_lanes_zero: assert property (@(posedge clk_sys) disable iff (rst)
        avs_readdata[31:8] == 24'h0)
        else $error("Upper read data lanes not zero.");

    a_rx_end_sets: assert property (@(posedge clk_sys) disable iff (rst)  // [R14]
        (engine_events.receive_end_flag || receive_buffer_full) |=> flags[hli_pkg::BIT_RX_END])
        else $error("Receive end did not set its flag.");

    a_tx_start_sets: assert property (@(posedge clk_sys) disable iff (rst)  // [R15]
        engine_events.transmit_start_flag |=> flags[hli_pkg::BIT_TX_START])
        else $error("Transmit start did not set its flag.");

    a_tx_end_sets: assert property (@(posedge clk_sys) disable iff (rst)  // [R15]
        engine_events.transmit_end_flag |=> flags[hli_pkg::BIT_TX_END])
        else $error("Transmit end did not set its flag.");

    a_kind_bit_reads: assert property (@(posedge clk_sys) disable iff (rst)  // [R16]
        (!answering && avs_read && hit_status) |=> (avs_readdata[7] == $past(message_kind_bit)))
        else $error("Status read returned the wrong message kind.");

    a_irq_matches_flags: assert property (@(posedge clk_sys) disable iff (rst)  // [R17]
        irq == |(flags & enable))
        else $error("Interrupt does not match enabled flags.");

    a_masked_no_irq: assert property (@(posedge clk_sys) disable iff (rst)  // [R17]
        ((flags & enable) == 7'h00) |-> !irq)
        else $error("Interrupt raised with no enabled flag.");

    a_irq_drops_on_read: assert property (@(posedge clk_sys) disable iff (rst)  // [R17]
        (answering && avs_read && hit_status && events == 7'h00 && (flags & ~readdata[6:0]) == 7'h00) |=> !irq)
        else $error("Interrupt stayed high after the flags were read.");

    a_answer_one_wait: assert property (@(posedge clk_sys) disable iff (rst)
        ((avs_read || avs_write) && !answering) |-> avs_waitrequest ##1 !avs_waitrequest)
        else $error("Bus answer was not given after one wait cycle.");

    a_wait_low_idle: assert property (@(posedge clk_sys) disable iff (rst)
        !(avs_read || avs_write) |-> !avs_waitrequest)
        else $error("Waitrequest high without a request.");

    a_answer_single: assert property (@(posedge clk_sys) disable iff (rst)
        answering |=> !answering)
        else $error("Bus answer state held for more than one cycle.");

    a_bus_state_legal: assert property (@(posedge clk_sys) disable iff (rst)
        (bus_state == hli_pkg::HLI_BUS_IDLE || bus_state == hli_pkg::HLI_BUS_ANSWER))
        else $error("Bus state left its legal codes.");

endmodule

// File: tb.sv
// Self-checking testbench for the data link interrupt status and enable block.
`timescale 1ns/1ns
module tb;
    typedef struct packed {
        logic [3:0] src;
        logic       mk;
        logic [6:0] en;
        logic       irq;
        logic [7:0] st;
    } hli_row_t;
    localparam logic [17:0] A_ST  = {4'h1, hli_pkg::STATUS_INDEX_LOW, 2'h0};
    localparam logic [17:0] A_EN  = {4'h1, hli_pkg::ENABLE_INDEX_LOW, 2'h0};
    // Same register index on another channel, so the channel nibble decode is exercised.
    localparam logic [17:0] A_BAD = {4'h0, hli_pkg::ENABLE_INDEX_LOW, 2'h0};
    logic                        clk_sys             = 1'b0;
    logic                        rst                 = 1'b1;
    logic [17:0]                 avs_address         = 18'h0;
    logic                        avs_read            = 1'b0;
    logic                        avs_write           = 1'b0;
    logic [31:0]                 avs_writedata       = 32'h0;
    logic [3:0]                  avs_byteenable      = 4'hF;
    logic [31:0]                 avs_readdata;
    logic                        avs_waitrequest;
    hli_pkg::hli_engine_events_t engine_events       = '0;
    logic                        receive_buffer_full = 1'b0;
    logic                        message_kind_bit    = 1'b0;
    logic                        rx_line_bit         = 1'b0;
    logic                        rx_line_valid       = 1'b0;
    logic                        irq;
    logic [31:0]                 q;
    int                          errors              = 0;
    int                          checks              = 0;
    int                          cycles              = 0;
    hli_row_t                    rows [11];

    hli_irq_status #(.CHANNEL(4'h1)) uut (
        .clk_sys(clk_sys), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .engine_events(engine_events),
        .receive_buffer_full(receive_buffer_full), .message_kind_bit(message_kind_bit),
        .rx_line_bit(rx_line_bit), .rx_line_valid(rx_line_valid), .irq(irq));

    initial begin
        forever #50 clk_sys = ~clk_sys;
    end

    task automatic wrap_up();
        if (errors == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            errors++;
            wrap_up();
        end
    end

    task automatic chk(input logic ok, input string msg);
        checks++;
        if (ok !== 1'b1) begin
            errors++;
            $display("MISMATCH at %0t: %s", $time, msg);
        end
    endtask

    // Waitrequest and read data are taken at the rising edge, before that edge's own updates land.
    task automatic acc(input logic wr, input logic [17:0] a, input logic [7:0] d, output logic [31:0] r);
        @(posedge clk_sys);
        avs_address   <= a;
        avs_write     <= wr;
        avs_read      <= ~wr;
        avs_writedata <= {24'h0, d};
        do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
        r = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
    endtask

    task automatic fire(input logic [3:0] s);
        logic [7:0] v;
        v = (s == 4'h0) ? hli_pkg::IDLE_OCTET : 8'h7F;
        @(posedge clk_sys);
        if (s < 4'h2) begin
            for (int k = 7; k >= 0; k--) begin
                rx_line_bit   <= v[k];
                rx_line_valid <= 1'b1;
                @(posedge clk_sys);
            end
            rx_line_valid <= 1'b0;
        end else if (s == 4'h7) begin
            receive_buffer_full <= 1'b1;
            @(posedge clk_sys);
            receive_buffer_full <= 1'b0;
        end else begin
            engine_events <= hli_pkg::hli_engine_events_t'(5'h01 << (s - 4'h2));
            @(posedge clk_sys);
            engine_events <= '0;
        end
    endtask

    initial begin
        rows = '{'{4'h0, 1'b0, 7'h01, 1'b1, 8'h01}, '{4'h1, 1'b0, 7'h02, 1'b1, 8'h02},
                 '{4'h2, 1'b0, 7'h04, 1'b1, 8'h04}, '{4'h3, 1'b0, 7'h08, 1'b1, 8'h08},
                 '{4'h4, 1'b0, 7'h10, 1'b1, 8'h10}, '{4'h5, 1'b0, 7'h20, 1'b1, 8'h20},
                 '{4'h6, 1'b0, 7'h40, 1'b1, 8'h40}, '{4'h7, 1'b0, 7'h08, 1'b1, 8'h08},
                 '{4'h2, 1'b0, 7'h7B, 1'b0, 8'h04}, '{4'h6, 1'b1, 7'h3F, 1'b0, 8'hC0},
                 '{4'h0, 1'b0, 7'h7E, 1'b0, 8'h01}};
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        acc(1'b0, A_ST, 8'h00, q);
        chk(q === 32'h0 && irq === 1'b0, "status after reset");
        acc(1'b1, A_EN, 8'hFF, q);
        acc(1'b0, A_EN, 8'h00, q);
        chk(q === 32'h7F, "reserved enable bit");
        for (int i = 0; i < 11; i++) begin
            message_kind_bit <= rows[i].mk;
            acc(1'b1, A_EN, {1'b0, rows[i].en}, q);
            acc(1'b0, A_EN, 8'h00, q);
            chk(q === {25'h0, rows[i].en}, "enable readback");
            fire(rows[i].src);
            @(negedge clk_sys);
            chk(irq === rows[i].irq, "irq after event");
            acc(1'b0, A_ST, 8'h00, q);
            chk(q === {24'h0, rows[i].st}, "status flags");
            @(negedge clk_sys);
            chk(irq === 1'b0, "irq after status read");
            acc(1'b0, A_ST, 8'h00, q);
            chk(q === {24'h0, rows[i].mk, 7'h00}, "flags cleared by read");
        end
        acc(1'b1, A_BAD, 8'h7F, q);
        acc(1'b0, A_BAD, 8'h00, q);
        chk(q === 32'h0, "unmapped read");
        avs_byteenable <= 4'hE;
        acc(1'b1, A_EN, 8'h7F, q);
        avs_byteenable <= 4'hF;
        acc(1'b0, A_EN, 8'h00, q);
        chk(q === 32'h7E, "enable kept");
        // Idle octet and receive end together are what software takes as a whole message.
        fire(4'h0);
        fire(4'h3);
        acc(1'b0, A_ST, 8'h00, q);
        chk(q === 32'h09, "idle with end");
        // A flag raised while masked must stay and raise the interrupt once enabled.
        acc(1'b1, A_EN, 8'h00, q);
        fire(4'h2);
        @(negedge clk_sys);
        chk(irq === 1'b0, "masked flag");
        acc(1'b1, A_EN, 8'h04, q);
        @(negedge clk_sys);
        chk(irq === 1'b1, "late enable");
        acc(1'b1, A_ST, 8'h04, q);
        @(negedge clk_sys);
        chk(irq === 1'b0, "write one clear");
        acc(1'b1, A_EN, 8'h7F, q);
        fire(4'h5);
        @(negedge clk_sys);
        chk(irq === 1'b1, "irq before reset");
        @(posedge clk_sys);
        rst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        @(negedge clk_sys);
        chk(irq === 1'b0, "irq after second reset");
        acc(1'b0, A_ST, 8'h00, q);
        chk(q === 32'h0, "status after second reset");
        acc(1'b0, A_EN, 8'h00, q);
        chk(q === 32'h0, "enable after second reset");
        wrap_up();
    end
endmodule
